// ==== inc/sfq_pkg.sv ====
package sfq_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0]  SFQ_ADR_CTRL   = 8'h00;
    localparam logic [7:0]  SFQ_ADR_BAUD   = 8'h04;
    localparam logic [7:0]  SFQ_ADR_STAT   = 8'h08;
    localparam logic [7:0]  SFQ_ADR_DATA   = 8'h0C;

    // Control field positions
    localparam int          SFQ_CTRL_RXEN  = 0;
    localparam int          SFQ_CTRL_NINE  = 1;
    localparam int          SFQ_CTRL_TWOSB = 2;
    localparam int          SFQ_CTRL_PAREN = 3;
    localparam int          SFQ_CTRL_PODD  = 4;
    localparam int          SFQ_CTRL_IRQEN = 5;

    // Status field positions
    localparam int          SFQ_STAT_FULL  = 0;
    localparam int          SFQ_STAT_FE    = 1;
    localparam int          SFQ_STAT_PE    = 2;
    localparam int          SFQ_STAT_OVR   = 3;
    localparam int          SFQ_STAT_BUSY  = 4;

    // Timing: bit period derived from clock and default line rate
    localparam int          SFQ_CLK_HZ     = 20_000_000;
    localparam int          SFQ_BAUD_BPS   = 115_200;
    localparam int          SFQ_BIT_CYC    = SFQ_CLK_HZ / SFQ_BAUD_BPS;
    localparam logic [15:0] SFQ_BAUD_RST   = 16'(SFQ_BIT_CYC);

    // Frame geometry
    localparam logic [3:0]  SFQ_BITS_8     = 4'h8;
    localparam logic [3:0]  SFQ_BITS_9     = 4'h9;
    localparam logic [3:0]  SFQ_BITS_QUIRK = 4'hA;

    typedef struct packed {
        logic irq_en;
        logic par_odd;
        logic par_en;
        logic two_stop;
        logic nine_bits;
        logic rx_en;
    } sfq_cfg_t;

    localparam sfq_cfg_t    SFQ_CFG_RST    = '0;

    typedef enum logic [2:0] {
        SFQ_IDLE,
        SFQ_START,
        SFQ_DATA,
        SFQ_PAR,
        SFQ_STOP1,
        SFQ_STOP2,
        SFQ_GHOST
    } sfq_state_t;

endpackage

// ==== hdl/sfq_bit_timer.sv ====
`timescale 1ns/10ps
module sfq_bit_timer
    import sfq_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Control
    input  wire logic         restart_i,
    input  wire logic [W-1:0] div_i,
    // Mid-bit strobe
    output logic              mid_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } sfq_tmr_t;

    sfq_tmr_t s;
    sfq_tmr_t next_s;

    // Free counter wrapping once per bit period; restart aligns to a start edge
    always_comb begin
        next_s = s;
        if (restart_i || (s.cnt >= div_i - W'(1))) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Sample point half a bit in, so edges of the line are avoided
    assign mid_o = (s.cnt == (div_i >> 1));

endmodule

// ==== hdl/sfq_rx.sv ====
`timescale 1ns/10ps
// Operation
// - In one-stop-bit format each received frame raises the full flag twice, the second time spuriously.
// - The spurious second full indication comes one bit period after the genuine one.
// - A next frame starting within one bit period of the previous one also raises a framing error.
// - A status read followed by a data read clears the full flag and the other flags; the data read returns the byte.
// - Nine data bits with two stop bits and no parity shifts the first stop bit into the data MSB, losing the LSB.
// - Nine data bits with two stop bits and parity takes the first stop bit as parity and shifts the LSB out.
module sfq_rx
    import sfq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial line and interrupt
    input  wire logic        rxd_i,
    output logic             irq_o
);

    typedef struct packed {
        sfq_state_t  st;
        logic [8:0]  sh;
        logic [3:0]  bcnt;
        logic        acc;
        logic        fe_p;
        logic        pe_p;
        logic [8:0]  data;
        sfq_cfg_t    cfg;
        logic [15:0] div;
        logic        full;
        logic        fe;
        logic        pe;
        logic        ovr;
        logic        armed;
        logic        ack;
        logic [31:0] rdat;
        logic        irq;
        logic [15:0] gap;
    } sfq_top_t;

    sfq_top_t s;
    sfq_top_t next_s;

    logic        mid;
    logic        restart;
    logic        take;
    logic        stat_rd;
    logic        data_rd;
    logic        clear;
    logic        frame_set;
    logic        ghost_set;
    logic        quirk;
    logic [3:0]  target;
    logic [4:0]  stat_word;

    ////////////////////////////////////////////////////////////////////////////
    // Bit timing

    sfq_bit_timer #(
        .W         (16)
    ) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (restart),
        .div_i     (s.div),
        .mid_o     (mid)
    );

    // Start edge seen while idle re-phases the bit timer
    assign restart = (s.st == SFQ_IDLE) && s.cfg.rx_en && !rxd_i;

    // Nine bits plus two stop bits makes the shifter run one bit long
    assign quirk  = s.cfg.nine_bits && s.cfg.two_stop;
    assign target = quirk ? SFQ_BITS_QUIRK : (s.cfg.nine_bits ? SFQ_BITS_9 : SFQ_BITS_8);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign take    = wb_cyc_i && wb_stb_i && !s.ack;
    assign stat_rd = take && !wb_we_i && (wb_adr_i == SFQ_ADR_STAT);
    assign data_rd = take && !wb_we_i && (wb_adr_i == SFQ_ADR_DATA);
    // Clearing needs the status read first; a lone data read leaves flags alone
    assign clear   = data_rd && s.armed;

    assign stat_word = {(s.st != SFQ_IDLE), s.ovr, s.pe, s.fe, s.full};

    ////////////////////////////////////////////////////////////////////////////
    // Next state: receiver, flags and register file

    always_comb begin
        next_s    = s;
        frame_set = 1'b0;
        ghost_set = 1'b0;
        next_s.gap = (s.gap == 16'hFFFF) ? s.gap : s.gap + 16'h0001;

        // Receiver sequence, advancing at mid-bit samples, except on leaving idle at a start edge
        unique case (s.st)
            SFQ_IDLE: begin
                if (restart) begin
                    next_s.st   = SFQ_START;
                    next_s.bcnt = '0;
                    next_s.acc  = 1'b0;
                    next_s.fe_p = 1'b0;
                    next_s.pe_p = 1'b0;
                end
            end
            SFQ_START: begin
                if (mid) begin
                    next_s.st = rxd_i ? SFQ_IDLE : SFQ_DATA; // Glitch rejected
                end
            end
            SFQ_DATA: begin
                if (mid) begin
                    next_s.sh   = {rxd_i, s.sh[8:1]};
                    next_s.acc  = s.acc ^ rxd_i;
                    next_s.bcnt = s.bcnt + 4'h1;
                    if (s.bcnt + 4'h1 == target) begin
                        if (s.cfg.par_en) begin
                            next_s.st = SFQ_PAR;
                        end else begin
                            next_s.st = quirk ? SFQ_STOP2 : SFQ_STOP1;
                        end
                    end
                end
            end
            SFQ_PAR: begin
                if (mid) begin
                    // In the long format this sample is really the first stop bit
                    next_s.pe_p = s.acc ^ rxd_i ^ s.cfg.par_odd;
                    next_s.st   = quirk ? SFQ_STOP2 : SFQ_STOP1;
                end
            end
            SFQ_STOP1: begin
                if (mid) begin
                    if (s.cfg.two_stop) begin
                        next_s.fe_p = s.fe_p | !rxd_i;
                        next_s.st   = SFQ_STOP2;
                    end else begin
                        next_s.fe_p = s.fe_p | !rxd_i;
                        frame_set   = 1'b1;
                        next_s.st   = SFQ_GHOST;
                    end
                end
            end
            SFQ_STOP2: begin
                if (mid) begin
                    next_s.fe_p = s.fe_p | !rxd_i;
                    frame_set   = 1'b1;
                    next_s.st   = SFQ_IDLE;
                end
            end
            SFQ_GHOST: begin
                // Blind for one bit: a start edge here is missed, so frames need a gap
                if (mid) begin
                    ghost_set = 1'b1;
                    next_s.st = SFQ_IDLE;
                end
            end
        endcase

        if (!s.cfg.rx_en) begin
            next_s.st = SFQ_IDLE;
        end

        // Received byte lands in the data register; 8-bit frames sit high in the shifter
        if (frame_set) begin
            next_s.data = s.cfg.nine_bits ? next_s.sh : {1'b0, next_s.sh[8:1]};
            next_s.gap  = 16'h0001;
        end

        // Sticky flags: a new set beats a clear in the same cycle, except overrun, which a coinciding clear suppresses
        next_s.full = (s.full & !clear) | frame_set | ghost_set;
        next_s.fe   = (s.fe & !clear) | (frame_set & next_s.fe_p)
                    | (ghost_set & !rxd_i);
        next_s.pe   = (s.pe & !clear) | (frame_set & next_s.pe_p);
        next_s.ovr  = (s.ovr & !clear) | (frame_set & s.full & !clear);

        // Status read arms the clear, data read consumes it
        if (stat_rd) begin
            next_s.armed = 1'b1;
        end else if (data_rd) begin
            next_s.armed = 1'b0;
        end

        // Wishbone: one-cycle registered answer, unmapped reads give zero
        next_s.ack = take;
        if (take && !wb_we_i) begin
            unique case (wb_adr_i)
                SFQ_ADR_CTRL: next_s.rdat = {26'h0000000, s.cfg};
                SFQ_ADR_BAUD: next_s.rdat = {16'h0000, s.div};
                SFQ_ADR_STAT: next_s.rdat = {27'h0000000, stat_word};
                SFQ_ADR_DATA: next_s.rdat = {23'h000000, s.data};
                default:      next_s.rdat = 32'h00000000;
            endcase
        end
        if (take && wb_we_i) begin
            if ((wb_adr_i == SFQ_ADR_CTRL) && wb_sel_i[0]) begin
                next_s.cfg.rx_en     = wb_dat_i[SFQ_CTRL_RXEN];
                next_s.cfg.nine_bits = wb_dat_i[SFQ_CTRL_NINE];
                next_s.cfg.two_stop  = wb_dat_i[SFQ_CTRL_TWOSB];
                next_s.cfg.par_en    = wb_dat_i[SFQ_CTRL_PAREN];
                next_s.cfg.par_odd   = wb_dat_i[SFQ_CTRL_PODD];
                next_s.cfg.irq_en    = wb_dat_i[SFQ_CTRL_IRQEN];
            end
            if ((wb_adr_i == SFQ_ADR_BAUD) && wb_sel_i[0]) begin
                next_s.div[7:0] = wb_dat_i[7:0];
            end
            if ((wb_adr_i == SFQ_ADR_BAUD) && wb_sel_i[1]) begin
                next_s.div[15:8] = wb_dat_i[15:8];
            end
        end

        // Interrupt follows the flag, so it holds until the clearing sequence
        next_s.irq = next_s.full & next_s.cfg.irq_en;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s      <= '0;
            s.st   <= SFQ_IDLE;
            s.cfg  <= SFQ_CFG_RST;
            s.div  <= SFQ_BAUD_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign irq_o    = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_GHOST_FOLLOWS: assert property (
        (frame_set && !s.cfg.two_stop) |=> (s.st == SFQ_GHOST) && s.full)
        else $error("one-stop frame did not enter the spurious flag phase");

    AST_GHOST_ONE_BIT: assert property (
        ghost_set |-> (s.gap == s.div))
        else $error("spurious full flag not one bit period after the genuine one");

    AST_SHORT_GAP_FE: assert property (
        (ghost_set && !rxd_i) |=> s.fe && s.full)
        else $error("short inter-frame gap gave no framing error");

    AST_CLEAR_SEQ: assert property (
        (stat_rd ##1 !take [*2] ##1 (data_rd && !frame_set && !ghost_set && !s.ovr))
        |=> !s.full && !s.fe && !s.pe)
        else $error("status then data read did not clear the flags");

    AST_SET_WINS: assert property (
        (clear && (frame_set || ghost_set)) |=> s.full)
        else $error("flag set lost against a clear");

    AST_QUIRK_NOPAR: assert property (
        (frame_set && quirk && !s.cfg.par_en) |-> (s.bcnt == SFQ_BITS_QUIRK)
        ##1 (s.data == s.sh))
        else $error("long format without parity did not shift the stop bit in");

    AST_QUIRK_PAR: assert property (
        (s.st == SFQ_PAR && mid && quirk) |=> (s.st == SFQ_STOP2)
        && ($past(s.bcnt) == SFQ_BITS_QUIRK))
        else $error("long format with parity did not take a stop bit as parity");

    AST_IRQ_LEVEL: assert property (
        (s.full && s.cfg.irq_en) |-> irq_o ##1 (irq_o || !s.full || !s.cfg.irq_en))
        else $error("receive interrupt not held while full flag set");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

// ==== dv/sfq_tx_model.sv ====
`timescale 1ns/10ps
module sfq_tx_model
    import sfq_pkg::*;
#(
    parameter int DIV = 8
) (
    // Clock
    input  wire logic clk_i,
    // Serial line, idle high
    output logic      txd_o
);
    // Line rests high until the first frame is shifted
    initial txd_o = 1'b1;

    // Shifts 32 bits LSB first, each held DIV cycles; the caller pads with
    // ones, which is the idle gap between frames
    task automatic send(input logic [31:0] bits);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_i);
            txd_o <= bits[i];
            repeat (DIV - 1) @(posedge clk_i);
        end
    endtask
endmodule

// ==== dv/tb_sfq_rx.sv ====
`timescale 1ns/10ps
module tb_sfq_rx
    import sfq_pkg::*;
;
    localparam int DIV = 16;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        rxd_i;
    logic        irq_o;
    logic [31:0] rd;
    int          miscompares = 0;
    int          compares = 0;
    int          cyc_n = 0;
    int          t1;
    // Nine plus two without and with parity, then eight bits, odd parity, two stops
    logic [31:0] cf [3] = '{32'h27, 32'h2F, 32'h3D};
    logic [31:0] fr [3] = '{32'hFFFF_FD66, 32'hFFFF_F964, 32'hFFFF_FEB4};
    logic [31:0] ex [3] = '{32'h159, 32'h059, 32'h05A};
    logic [31:0] sx [3] = '{32'h01, 32'h05, 32'h01};

    // Clock and cycle count used to time the spurious flag
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    sfq_rx dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rxd_i(rxd_i), .irq_o(irq_o)
    );

    sfq_tx_model #(.DIV(DIV)) tx (.clk_i(clk_i), .txd_o(rxd_i));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic final_report();
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compare of one bus or port value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic cycle; request held until ack is seen high at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        // Read data taken at the same edge that saw ack, then released
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            final_report();
        end
    endtask

    // Bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (irq_o !== lvl && n < 1000);
        if (n >= 1000) begin
            miscompares++;
            final_report();
        end
    endtask

    // Reset held four cycles, line idle meanwhile
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset();
        wb(1'b0, SFQ_ADR_BAUD, 32'h0);
        chk("baud reset", 32'h0000_00AD, rd);
        wb(1'b1, SFQ_ADR_STAT, 32'hFF);
        wb(1'b1, 8'h10, 32'hFF);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        chk("status reset", 32'h0, rd);
        wb(1'b1, SFQ_ADR_BAUD, 32'(DIV));
        // One stop bit: clear fast, then the spurious flag must return
        wb(1'b1, SFQ_ADR_CTRL, 32'h21);
        fork tx.send(32'hFFFF_FF4A); join_none
        wait_irq(1'b1);
        t1 = cyc_n;
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        chk("first status", 32'h11, rd);
        wb(1'b0, SFQ_ADR_DATA, 32'h0);
        chk("first data", 32'hA5, rd);
        wait_irq(1'b0);
        wait_irq(1'b1);
        chk("ghost delay", 32'(DIV), 32'(cyc_n - t1));
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        chk("ghost status", 32'h01, rd);
        wb(1'b0, SFQ_ADR_DATA, 32'h0);
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        chk("cleared", 32'h0, rd);
        wait_irq(1'b0);
        wait fork;
        // Clear landing on the spurious flag sample: the set must win
        fork tx.send(32'hFFFF_FF4A); join_none
        wait_irq(1'b1);
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        // Places the data read's taking edge on the spurious sample point
        repeat (DIV - 5) @(posedge clk_i);
        wb(1'b0, SFQ_ADR_DATA, 32'h0);
        chk("racing data", 32'hA5, rd);
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        chk("set beats clear", 32'h01, rd);
        wait fork;
        // Two frames with no idle gap raise a framing error
        tx.send(32'hFFFE_1A78);
        wb(1'b0, SFQ_ADR_STAT, 32'h0);
        chk("frame err", 32'h1, {31'h0, rd[SFQ_STAT_FE]});
        // Two stop bit formats, nine data bits without and with parity, then eight
        for (int k = 0; k < 3; k++) begin
            do_reset();
            wb(1'b1, SFQ_ADR_BAUD, 32'(DIV));
            wb(1'b1, SFQ_ADR_CTRL, cf[k]);
            fork tx.send(fr[k]); join_none
            wait_irq(1'b1);
            repeat (DIV) @(posedge clk_i);
            wb(1'b0, SFQ_ADR_STAT, 32'h0);
            chk("frame status", sx[k], rd);
            wb(1'b0, SFQ_ADR_DATA, 32'h0);
            chk("frame data", ex[k], rd);
            wait fork;
        end
        final_report();
    end

    // Watchdog far beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        final_report();
    end
endmodule
